/* File: shared/lpw_pkg.sv */
// lpw_pkg: constants, register layout and types for the low-power wake-up and warm-up controller
// assumes a single 100 MHz core clock domain; nothing here holds state
package lpw_pkg;

   // ------------------------------------------------------------
   // register map, word addresses on the plain register port
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_STANDBY_CTRL  = 4'h0;
   localparam logic [3:0] ADDR_OSC_CTRL      = 4'h1;
   localparam logic [3:0] ADDR_WAKE_ENABLE   = 4'h2;
   localparam logic [3:0] ADDR_STATUS        = 4'h3;
   localparam logic [3:0] ADDR_SW_WARMUP     = 4'h4;

   // ------------------------------------------------------------
   // fields
   // ------------------------------------------------------------
   localparam int STBY_LSB        = 0;
   localparam int STBY_W          = 3;
   localparam int WARMUP_TIME_FIELD_LSB        = 0;
   localparam int WARMUP_TIME_FIELD_W          = 3;
   localparam int WARMUP_OSC_SELECT_BIT      = 4;
   localparam int HS_EN_BIT       = 8;
   localparam int LS_EN_BIT       = 9;
   localparam int SLOW_SEL_BIT    = 10;
   localparam int WAKE_W          = 5;
   localparam int SW_WARMUP_BIT   = 0;

   localparam logic [2:0] STBY_STOP  = 3'h1;
   localparam logic [2:0] STBY_SLEEP = 3'h2;
   localparam logic [2:0] STBY_IDLE  = 3'h3;

   localparam logic [2:0]  STBY_RESET  = 3'h0;
   localparam logic [2:0]  WARMUP_TIME_FIELD_RESET  = 3'h7;
   localparam logic [4:0]  WAKE_RESET  = 5'h00;

   // warm-up length: 2 ** (WARMUP_TIME_FIELD_BASE_LOG2 + field) oscillator cycles
   localparam int WARMUP_TIME_FIELD_BASE_LOG2 = 8;
   localparam int WCNT_W         = 16;

   // wake enable bits inside the wake-detection register (sleep/stop sources)
   localparam int WK_EXT    = 0;
   localparam int WK_CAL    = 1;
   localparam int WK_LINK   = 2;
   localparam int WK_REMOTE = 3;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      LPW_RUN    = 3'b000,
      LPW_IDLE   = 3'b001,
      LPW_SLEEP  = 3'b011,
      LPW_STOP   = 3'b010,
      LPW_WARMUP = 3'b110,
      LPW_HANDLE = 3'b111
   } lpw_state_e;

   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } lpw_bus_s;

   // interrupt sources grouped by which modes they may release
   typedef struct packed {
      logic ext_irq;                    // external interrupt pins: all modes
      logic calendar_clock_irq;         // idle, sleep
      logic consumer_link_receive_irq;  // idle, sleep
      logic remote_receive_irq;         // idle, sleep
      logic timer_irq;                  // idle only
      logic capture_irq;
      logic serial_receive_irq;
      logic serial_transmit_irq;
      logic serial_bus_irq;
      logic converter_irq;
   } lpw_irq_s;

endpackage

/* File: logic/lpw_warmup_counter.sv */
// lpw_warmup_counter: counts oscillator ticks up to a power-of-two limit
// assumes the tick strobes arrive already synchronised to the core clock
`timescale 1ns/1ps
`default_nettype none
module lpw_warmup_counter #(
   parameter int CNT_W = lpw_pkg::WCNT_W
) (
   // clock and reset
   input  wire logic             core_clk_in,
   input  wire logic             rst_in,
   // control
   input  wire logic             start_in,
   input  wire logic             tick_in,
   input  wire logic [2:0]       time_in,
   // result
   output logic                  done_out,
   output logic                  busy_out
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] limit;
   logic             busy_q;
   logic             done_q;
   logic             at_end;

   assign limit  = CNT_W'((32'h1 << (lpw_pkg::WARMUP_TIME_FIELD_BASE_LOG2 + int'(time_in))) - 32'h1);
   assign at_end = busy_q && tick_in && (cnt_q == limit);

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q  <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= at_end;
         if (start_in) begin
            cnt_q  <= '0;
            busy_q <= 1'b1;
         end else if (at_end) begin
            busy_q <= 1'b0;
         end else if (busy_q && tick_in) begin
            cnt_q  <= cnt_q + CNT_W'(1);
         end
      end
   end

   assign done_out = done_q;
   assign busy_out = busy_q;

endmodule // lpw_warmup_counter
`default_nettype wire

/* File: logic/lpw_wakeup_ctrl.sv */
// lpw_wakeup_ctrl: low-power mode entry, wake-source qualification and warm-up gating
// assumes core software drives the register port; pins and oscillator ticks are asynchronous
`timescale 1ns/1ps
`default_nettype none
module lpw_wakeup_ctrl (
   // clock and reset
   input  wire logic                core_clk_in,
   input  wire logic                rst_in,
   // register port
   input  wire logic [3:0]          reg_addr_in,
   input  wire logic [31:0]         reg_wdata_in,
   input  wire logic                reg_wr_in,
   input  wire logic                reg_rd_in,
   output logic      [31:0]         reg_rdata_out,
   // core handshake
   input  wire logic                standby_req_in,
   // asynchronous wake sources
   input  wire lpw_pkg::lpw_irq_s   irq_in,
   input  wire logic                watchdog_nmi_request_in,
   input  wire logic                nmi_pin_in,
   // oscillator ticks, asynchronous
   input  wire logic                hs_osc_tick_in,
   input  wire logic                ls_osc_tick_in,
   // outputs
   output logic                     sys_clk_enable_out,
   output logic                     core_halt_out,
   output logic                     wake_irq_out,
   output logic                     wake_nmi_out,
   output logic                     hs_osc_enable_out,
   output logic                     ls_osc_enable_out,
   output logic                     pll_enable_out,
   output logic                     slow_mode_out
);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   lpw_pkg::lpw_state_e state_q, state_d;
   logic [2:0]  standby_field_q;
   logic [2:0]  warmup_time_field_q;
   logic        warmup_osc_select_q;
   logic        hs_en_q;
   logic        ls_en_q;
   logic        slow_q;
   logic        slow_before_q;
   logic [lpw_pkg::WAKE_W-1:0] wake_en_q;
   logic [31:0] rdata_q;
   logic        wake_irq_q;
   logic        wake_nmi_q;
   logic        sw_warm_q;

   // ------------------------------------------------------------
   // synchronisers
   // ------------------------------------------------------------
   localparam int NSYNC = $bits(lpw_pkg::lpw_irq_s) + 4;
   logic [NSYNC-1:0] sync1_q, sync2_q;
   logic [1:0]       tick_prev_q;

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sync1_q     <= '0;
         sync2_q     <= '0;
         tick_prev_q <= '0;
      end else begin
         sync1_q     <= {irq_in, watchdog_nmi_request_in, nmi_pin_in, hs_osc_tick_in, ls_osc_tick_in};
         sync2_q     <= sync1_q;
         tick_prev_q <= sync2_q[1:0];
      end
   end

   lpw_pkg::lpw_irq_s irq_s;
   wire wdt_s  = sync2_q[3];
   wire nmi_s  = sync2_q[2];
   assign irq_s = lpw_pkg::lpw_irq_s'(sync2_q[NSYNC-1:4]);

   // rising edges of the synchronised oscillator ticks
   wire hs_tick = sync2_q[1] && !tick_prev_q[1];
   wire ls_tick = sync2_q[0] && !tick_prev_q[0];

   // ------------------------------------------------------------
   // wake qualification
   // ------------------------------------------------------------
   wire periph_any = irq_s.timer_irq | irq_s.capture_irq | irq_s.serial_receive_irq
                   | irq_s.serial_transmit_irq | irq_s.serial_bus_irq | irq_s.converter_irq;
   wire all_irq    = periph_any | irq_s.ext_irq | irq_s.calendar_clock_irq
                   | irq_s.consumer_link_receive_irq | irq_s.remote_receive_irq;
   wire sleep_irq  = (irq_s.ext_irq & wake_en_q[lpw_pkg::WK_EXT])
                   | (irq_s.calendar_clock_irq & wake_en_q[lpw_pkg::WK_CAL])
                   | (irq_s.consumer_link_receive_irq & wake_en_q[lpw_pkg::WK_LINK])
                   | (irq_s.remote_receive_irq & wake_en_q[lpw_pkg::WK_REMOTE]);
   wire stop_irq   = irq_s.ext_irq & wake_en_q[lpw_pkg::WK_EXT];

   wire idle_wake_irq  = all_irq;
   wire idle_wake_nmi  = wdt_s | nmi_s;
   wire deep_wake_nmi  = nmi_s;

   // ------------------------------------------------------------
   // warm-up counter
   // ------------------------------------------------------------
   logic warm_start;
   logic warm_done;
   logic warm_busy;
   wire  warm_tick = warmup_osc_select_q ? ls_tick : hs_tick;

   lpw_warmup_counter #(
      .CNT_W (lpw_pkg::WCNT_W)
   ) u_warm (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .start_in    (warm_start),
      .tick_in     (warm_tick),
      .time_in     (warmup_time_field_q),
      .done_out    (warm_done),
      .busy_out    (warm_busy)
   );

   // ------------------------------------------------------------
   // mode sequencing
   // ------------------------------------------------------------
   // standby field decode
   wire ent_stop  = standby_field_q == lpw_pkg::STBY_STOP;
   wire ent_sleep = standby_field_q == lpw_pkg::STBY_SLEEP;
   wire ent_idle  = standby_field_q == lpw_pkg::STBY_IDLE;

   logic wake_now;
   logic wake_is_nmi;
   logic auto_warm;

   always_comb begin
      state_d     = state_q;
      wake_now    = 1'b0;
      wake_is_nmi = 1'b0;
      auto_warm   = 1'b0;
      case (state_q)
         lpw_pkg::LPW_RUN: begin
            if (standby_req_in && ent_idle) begin
               state_d = lpw_pkg::LPW_IDLE;
            end else if (standby_req_in && ent_sleep) begin
               state_d = lpw_pkg::LPW_SLEEP;
            end else if (standby_req_in && ent_stop) begin
               state_d = lpw_pkg::LPW_STOP;
            end
         end
         lpw_pkg::LPW_IDLE: begin
            wake_now    = idle_wake_irq | idle_wake_nmi;
            wake_is_nmi = idle_wake_nmi;
         end
         lpw_pkg::LPW_SLEEP: begin
            wake_now    = sleep_irq | deep_wake_nmi;
            wake_is_nmi = deep_wake_nmi;
            auto_warm   = !slow_before_q;
         end
         lpw_pkg::LPW_STOP: begin
            wake_now    = stop_irq | deep_wake_nmi;
            wake_is_nmi = deep_wake_nmi;
            auto_warm   = 1'b1;
         end
         lpw_pkg::LPW_WARMUP: begin
            if (warm_done) begin
               state_d = lpw_pkg::LPW_HANDLE;
            end
         end
         lpw_pkg::LPW_HANDLE: begin
            state_d = lpw_pkg::LPW_RUN;
         end
         default: begin
            state_d = lpw_pkg::LPW_RUN;
         end
      endcase
      if (wake_now) begin
         state_d = auto_warm ? lpw_pkg::LPW_WARMUP : lpw_pkg::LPW_HANDLE;
      end
   end

   assign warm_start = (wake_now && auto_warm) || sw_warm_q;

   // ------------------------------------------------------------
   // register port decode
   // ------------------------------------------------------------
   wire wr_stby = reg_wr_in && (reg_addr_in == lpw_pkg::ADDR_STANDBY_CTRL);
   wire wr_osc  = reg_wr_in && (reg_addr_in == lpw_pkg::ADDR_OSC_CTRL);
   wire wr_wake = reg_wr_in && (reg_addr_in == lpw_pkg::ADDR_WAKE_ENABLE);
   wire wr_swu  = reg_wr_in && (reg_addr_in == lpw_pkg::ADDR_SW_WARMUP)
                && reg_wdata_in[lpw_pkg::SW_WARMUP_BIT];

   wire [31:0] osc_word = {21'h0, slow_q, ls_en_q, hs_en_q, 3'h0, warmup_osc_select_q, 1'b0, warmup_time_field_q};
   wire [31:0] stat_word = {24'h0, warm_busy, slow_before_q, 3'h0, state_q};
   logic [31:0] rd_mux;
   always_comb begin
      case (reg_addr_in)
         lpw_pkg::ADDR_STANDBY_CTRL: rd_mux = {29'h0, standby_field_q};
         lpw_pkg::ADDR_OSC_CTRL:     rd_mux = osc_word;
         lpw_pkg::ADDR_WAKE_ENABLE:  rd_mux = {27'h0, wake_en_q};
         lpw_pkg::ADDR_STATUS:       rd_mux = stat_word;
         default:                    rd_mux = 32'h0;
      endcase
   end

   // ------------------------------------------------------------
   // state and register updates
   // ------------------------------------------------------------
   // reset returns to normal
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q             <= lpw_pkg::LPW_RUN;
         standby_field_q     <= lpw_pkg::STBY_RESET;
         warmup_time_field_q <= lpw_pkg::WARMUP_TIME_FIELD_RESET;
         warmup_osc_select_q <= 1'b0;
         hs_en_q             <= 1'b1;
         ls_en_q             <= 1'b1;
         slow_q              <= 1'b0;
         slow_before_q       <= 1'b0;
         wake_en_q           <= lpw_pkg::WAKE_RESET;
         rdata_q             <= 32'h0;
         sw_warm_q           <= 1'b0;
      end else begin
         state_q   <= state_d;
         rdata_q   <= reg_rd_in ? rd_mux : 32'h0;
         sw_warm_q <= wr_swu;
         if (wr_stby) begin
            standby_field_q <= reg_wdata_in[lpw_pkg::STBY_LSB +: lpw_pkg::STBY_W];
         end
         if (wr_osc) begin
            warmup_time_field_q <= reg_wdata_in[lpw_pkg::WARMUP_TIME_FIELD_LSB +: lpw_pkg::WARMUP_TIME_FIELD_W];
            warmup_osc_select_q <= reg_wdata_in[lpw_pkg::WARMUP_OSC_SELECT_BIT];
            hs_en_q             <= reg_wdata_in[lpw_pkg::HS_EN_BIT];
            ls_en_q             <= reg_wdata_in[lpw_pkg::LS_EN_BIT];
            slow_q              <= reg_wdata_in[lpw_pkg::SLOW_SEL_BIT];
         end
         if (wr_wake) begin
            wake_en_q <= reg_wdata_in[lpw_pkg::WAKE_W-1:0];
         end
         if (state_q == lpw_pkg::LPW_RUN && state_d != lpw_pkg::LPW_RUN) begin
            slow_before_q <= slow_q;
         end
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   wire deep_d = (state_d == lpw_pkg::LPW_SLEEP) || (state_d == lpw_pkg::LPW_STOP)
               || (state_d == lpw_pkg::LPW_WARMUP);
   wire stop_d = (state_d == lpw_pkg::LPW_STOP);
   wire run_d  = (state_d == lpw_pkg::LPW_RUN) || (state_d == lpw_pkg::LPW_HANDLE);

   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sys_clk_enable_out <= 1'b1;
         core_halt_out      <= 1'b0;
         wake_irq_out       <= 1'b0;
         wake_nmi_out       <= 1'b0;
         hs_osc_enable_out  <= 1'b1;
         ls_osc_enable_out  <= 1'b1;
         pll_enable_out     <= 1'b1;
         slow_mode_out      <= 1'b0;
         wake_irq_q         <= 1'b0;
         wake_nmi_q         <= 1'b0;
      end else begin
         wake_irq_q         <= wake_now && !wake_is_nmi ? 1'b1 : (state_d == lpw_pkg::LPW_RUN ? 1'b0 : wake_irq_q);
         wake_nmi_q         <= wake_now && wake_is_nmi ? 1'b1 : (state_d == lpw_pkg::LPW_RUN ? 1'b0 : wake_nmi_q);
         wake_irq_out       <= (state_d == lpw_pkg::LPW_HANDLE) && (wake_irq_q || (wake_now && !wake_is_nmi));
         wake_nmi_out       <= (state_d == lpw_pkg::LPW_HANDLE) && (wake_nmi_q || (wake_now && wake_is_nmi));
         sys_clk_enable_out <= run_d || (state_d == lpw_pkg::LPW_IDLE);
         core_halt_out      <= !run_d;
         ls_osc_enable_out  <= ls_en_q && !stop_d;
         hs_osc_enable_out  <= hs_en_q && !((state_d == lpw_pkg::LPW_SLEEP) || stop_d)
                            && !(run_d && slow_q && !hs_en_q);
         pll_enable_out     <= hs_en_q && !((state_d == lpw_pkg::LPW_SLEEP) || stop_d) && !slow_q;
         // return to prior mode; slow_before_q is stale on the entry edge
         slow_mode_out      <= (deep_d && (state_q != lpw_pkg::LPW_RUN)) ? slow_before_q : slow_q;
      end
   end

   assign reg_rdata_out = rdata_q;

endmodule // lpw_wakeup_ctrl
`default_nettype wire

/* File: bench/lpw_wakeup_ctrl_properties.sv */
// lpw_wakeup_ctrl_props: port-level checks on wake-up, clock gating and register read timing
// assumes the single core clock and the asynchronous active-high reset pin
`timescale 1ns/1ps
`default_nettype none
module lpw_wakeup_ctrl_props (
   // clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   // register port
   input  wire logic        reg_rd_in,
   input  wire logic [31:0] reg_rdata_out,
   // mode outputs
   input  wire logic        sys_clk_enable_out,
   input  wire logic        core_halt_out,
   input  wire logic        wake_irq_out,
   input  wire logic        wake_nmi_out,
   input  wire logic        slow_mode_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   a_reset_normal: assert property (
      $fell(rst_in) |-> (sys_clk_enable_out && !core_halt_out)[*3]) else $error("no normal run after reset");
   a_irq_pulse_one: assert property (
      wake_irq_out |=> !wake_irq_out) else $error("irq wake pulse too long");
   a_nmi_pulse_one: assert property (
      wake_nmi_out |=> !wake_nmi_out) else $error("nmi wake pulse too long");
   a_pulse_one_kind: assert property (
      !(wake_irq_out && wake_nmi_out)) else $error("both wake pulses at once");
   a_pulse_clock_on: assert property (
      (wake_irq_out || wake_nmi_out) |-> sys_clk_enable_out ##1 !core_halt_out) else $error("handling while gated");
   a_pulse_after_halt: assert property (
      (wake_irq_out || wake_nmi_out) |-> $past(core_halt_out, 2)) else $error("wake pulse without low power");
   a_halt_exit_wake: assert property (
      $fell(core_halt_out) |-> ##[0:1] (wake_irq_out || wake_nmi_out) or ($past(wake_irq_out) || $past(wake_nmi_out)))
      else $error("left low power without wake");
   a_gate_holds: assert property (
      $fell(sys_clk_enable_out) && !slow_mode_out |-> !sys_clk_enable_out[*8]) else $error("clock back too soon");
   a_gate_halts: assert property (
      !sys_clk_enable_out |-> core_halt_out) else $error("core runs without clock");
   a_read_quiet: assert property (
      !$past(reg_rd_in) |-> reg_rdata_out == 32'h0) else $error("read data outside read slot");
endmodule // lpw_wakeup_ctrl_props

bind lpw_wakeup_ctrl lpw_wakeup_ctrl_props u_props (
   .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
   .sys_clk_enable_out(sys_clk_enable_out), .core_halt_out(core_halt_out), .wake_irq_out(wake_irq_out),
   .wake_nmi_out(wake_nmi_out), .slow_mode_out(slow_mode_out));
`default_nettype wire

/* File: bench/lpw_osc_model.sv */
// lpw_osc_model: behavioural oscillator that toggles only while enabled
// assumes the enable comes from the controller; the tick is asynchronous to the core clock
`timescale 1ns/1ps
`default_nettype none
module lpw_osc_model #(
   parameter int HALF_NS = 20
) (
   // control
   input  wire logic enable_in,
   // oscillator output
   output var logic  tick_out
);
   // a stopped oscillator holds low, so a gated warm-up cannot count
   initial begin
      tick_out = 1'b0;
      forever begin
         if (enable_in === 1'b1) begin
            #HALF_NS tick_out = 1'b1;
            #HALF_NS tick_out = 1'b0;
         end else begin
            @(enable_in);
         end
      end
   end
endmodule // lpw_osc_model
`default_nettype wire

/* File: bench/testbench.sv */
// testbench: register-driven checks of low-power entry, wake sources and warm-up length
// assumes the controller's register port and two oscillator models at fixed rates
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic              core_clk_in;
   logic              rst_in;
   logic [3:0]        reg_addr_in;
   logic [31:0]       reg_wdata_in;
   logic              reg_wr_in;
   logic              reg_rd_in;
   logic [31:0]       reg_rdata_out;
   logic              standby_req_in;
   lpw_pkg::lpw_irq_s irq_in;
   logic              watchdog_nmi_request_in;
   logic              nmi_pin_in;
   logic              hs_osc_tick_in;
   logic              ls_osc_tick_in;
   logic              sys_clk_enable_out;
   logic              core_halt_out;
   logic              wake_irq_out;
   logic              wake_nmi_out;
   logic              hs_osc_enable_out;
   logic              ls_osc_enable_out;
   logic              pll_enable_out;
   logic              slow_mode_out;
   int                err_count;
   int                num_checks;
   int                n;
   logic              is_nmi;
   logic [31:0]       rd;
   // warm-up cases: sleep normal, stop normal, sleep slow, stop slow
   logic [31:0] c_osc [4] = '{32'h0000_0310, 32'h0000_0301, 32'h0000_0700, 32'h0000_0710};
   logic [4:0]  c_wen [4] = '{5'h02, 5'h03, 5'h02, 5'h01};
   logic [2:0]  c_mode[4] = '{3'h2, 3'h1, 3'h2, 3'h1};
   logic [9:0]  c_bad [4] = '{10'h2FF, 10'h1FF, 10'h2FF, 10'h1FF};
   int          c_src [4] = '{8, 11, 8, 9};
   int          c_tick[4] = '{256, 512, 0, 256};
   int          c_per [4] = '{4, 3, 4, 4};

   lpw_wakeup_ctrl uut (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .standby_req_in(standby_req_in), .irq_in(irq_in), .watchdog_nmi_request_in(watchdog_nmi_request_in),
      .nmi_pin_in(nmi_pin_in), .hs_osc_tick_in(hs_osc_tick_in), .ls_osc_tick_in(ls_osc_tick_in),
      .sys_clk_enable_out(sys_clk_enable_out), .core_halt_out(core_halt_out), .wake_irq_out(wake_irq_out),
      .wake_nmi_out(wake_nmi_out), .hs_osc_enable_out(hs_osc_enable_out), .ls_osc_enable_out(ls_osc_enable_out),
      .pll_enable_out(pll_enable_out), .slow_mode_out(slow_mode_out));
   lpw_osc_model #(.HALF_NS(15)) u_hs (.enable_in(hs_osc_enable_out), .tick_out(hs_osc_tick_in));
   lpw_osc_model #(.HALF_NS(20)) u_ls (.enable_in(ls_osc_enable_out), .tick_out(ls_osc_tick_in));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   function automatic logic [2:0] st_of(input logic [2:0] m);
      return (m == 3'h1) ? 3'h2 : (m == 3'h2) ? 3'h3 : (m == 3'h3) ? 3'h1 : 3'h0;
   endfunction
   task automatic report_and_stop();
      if (err_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic fail(input string m);
      err_count++;
      $display("FAIL %0t %s", $time, m);
   endtask
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
   endtask
   task automatic check_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) fail("flag mismatch");
   endtask
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge core_clk_in);
      reg_wr_in    <= 1'b0;
   endtask
   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge core_clk_in);
      reg_rd_in   <= 1'b0;
      #1 d = reg_rdata_out;
   endtask
   task automatic enter(input logic [2:0] m);
      reg_write(lpw_pkg::ADDR_STANDBY_CTRL, 32'(m));
      @(posedge core_clk_in);
      standby_req_in <= 1'b1;
      @(posedge core_clk_in);
      standby_req_in <= 1'b0;
      reg_read(lpw_pkg::ADDR_STATUS, rd);
      check_word(32'(rd[2:0]), 32'(st_of(m)));
   endtask
   task automatic drive_src(input int k, input logic v);
      @(posedge core_clk_in);
      if (k < 10) irq_in[k] <= v;
      else if (k == 10) watchdog_nmi_request_in <= v;
      else nmi_pin_in <= v;
   endtask
   task automatic wait_pulse(input int lim);
      n = 0;
      do begin
         @(posedge core_clk_in);
         #1 n++;
      end while (wake_irq_out !== 1'b1 && wake_nmi_out !== 1'b1 && n < lim);
      is_nmi = wake_nmi_out;
      if (n >= lim) begin
         fail("no wake pulse");
         report_and_stop();
      end
   endtask
   task automatic quiet(input int c);
      repeat (c) begin
         @(posedge core_clk_in);
         #1 check_bit(wake_irq_out | wake_nmi_out, 1'b0);
      end
   endtask

   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   initial begin
      {rst_in, reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in, standby_req_in} = {1'b1, 39'h0};
      {irq_in, watchdog_nmi_request_in, nmi_pin_in} = 12'h000;
      err_count = 0;
      num_checks = 0;
      repeat (12) @(posedge core_clk_in);
      rst_in <= 1'b0;
      reg_read(lpw_pkg::ADDR_OSC_CTRL, rd);
      check_word(rd, 32'h0000_0307);
      reg_read(lpw_pkg::ADDR_WAKE_ENABLE, rd);
      check_word(rd, 32'h0);
      reg_write(lpw_pkg::ADDR_STATUS, 32'h0000_00FF);
      reg_read(lpw_pkg::ADDR_STATUS, rd);
      check_word(rd, 32'h0);
      reg_write(4'hF, 32'hFFFF_FFFF);
      reg_read(4'hF, rd);
      check_word(rd, 32'h0);
      // every source releases idle, clock kept running
      for (int k = 0; k < 12; k++) begin
         enter(3'h3);
         check_bit(sys_clk_enable_out & core_halt_out, 1'b1);
         drive_src(k, 1'b1);
         wait_pulse(20);
         check_bit(is_nmi, k >= 10);
         drive_src(k, 1'b0);
         quiet(3);
      end
      for (int i = 0; i < 4; i++) begin
         reg_write(lpw_pkg::ADDR_OSC_CTRL, c_osc[i]);
         reg_write(lpw_pkg::ADDR_WAKE_ENABLE, 32'(c_wen[i]));
         enter(c_mode[i]);
         check_bit(pll_enable_out | hs_osc_enable_out, 1'b0);
         check_bit(ls_osc_enable_out, c_mode[i] != 3'h1);
         @(posedge core_clk_in);
         irq_in <= lpw_pkg::lpw_irq_s'(c_bad[i]);
         watchdog_nmi_request_in <= 1'b1;
         quiet(40);
         @(posedge core_clk_in);
         irq_in <= '0;
         watchdog_nmi_request_in <= 1'b0;
         drive_src(c_src[i], 1'b1);
         wait_pulse(2500);
         check_bit(n >= (c_tick[i] - 1) * c_per[i] && n <= c_tick[i] * c_per[i] + 12, 1'b1);
         check_bit(is_nmi, c_src[i] >= 10);
         check_bit(slow_mode_out, c_osc[i][10]);
         check_bit(pll_enable_out, !c_osc[i][10]);
         drive_src(c_src[i], 1'b0);
         quiet(3);
      end
      reg_write(lpw_pkg::ADDR_SW_WARMUP, 32'h0000_0001);
      reg_read(lpw_pkg::ADDR_STATUS, rd);
      check_bit(rd[7], 1'b1);
      repeat (1100) @(posedge core_clk_in);
      reg_read(lpw_pkg::ADDR_STATUS, rd);
      check_bit(rd[7], 1'b0);
      enter(3'h0);
      enter(3'h5);
      check_bit(core_halt_out, 1'b0);
      enter(3'h1);
      check_bit(sys_clk_enable_out, 1'b0);
      // reset held long enough for the oscillator to settle
      @(posedge core_clk_in);
      rst_in <= 1'b1;
      repeat (12) @(posedge core_clk_in);
      rst_in <= 1'b0;
      @(posedge core_clk_in);
      #1 check_bit(sys_clk_enable_out & ~core_halt_out, 1'b1);
      reg_read(lpw_pkg::ADDR_STANDBY_CTRL, rd);
      check_word(rd, 32'h0);
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
